// *** hdl/reset_watchdog_regs.vh ***
// Purpose: Constants for the reset and watchdog unit
// Assumes: Register bus offsets are byte indices of the 8-bit special register space
// Notes:   Counts derived from a 50 MHz system clock
// How it works
// - Six reset sources merge into one internal reset.
// - Shared reset pin is plain I/O unless the option selects reset.
// - Writing soft reset bit triggers a reset that keeps flags; hardware clears it.
// - Boot select bit picks application (0) or monitor (1) on restart.
// - Writing 0x20 restarts application, 0x60 restarts monitor.
// - After power recovery, reset stays active for 8192 clocks.
// - Optional extra power-up delay of about 45 ms.
// - Low supply sets the low-supply flag; only software clears it.
// - Flag is also set at power-up; software clears before relying on it.
// - Set low-supply flag requests interrupt when its enable is one.
// - Global enable zero blocks all interrupts; otherwise individual enables.
// - Low-supply priority bit selects high or low priority.
// - Power-on flag set by power cycle, cleared only by software.
// - Watchdog is 8-bit prescaler feeding 15-bit counter.
// - Watchdog enable bit starts counting; clearing it stops.
// - Watchdog restart bit zeroes the count and self-clears.
// - Overflow resets the system and sets the watchdog reset flag.
// - Count-in-sleep bit lets the watchdog run in idle mode.
// - Prescale field selects division 2^(field+1), 2 to 256.
// - Overflow after 12 x prescale x 32768 clocks from restart.
`ifndef RESET_WATCHDOG_REGS_VH
`define RESET_WATCHDOG_REGS_VH

`define ADDR_POWER_CONTROL      8'h87
`define ADDR_INTERRUPT_ENABLE   8'hA8
`define ADDR_INTERRUPT_PRIORITY 8'hB8
`define ADDR_WATCHDOG_CONTROL   8'hC1
`define ADDR_BOOT_PROGRAM_CTRL  8'hC7

`define BIT_LOW_SUPPLY_FLAG     5
`define BIT_POWER_ON_FLAG       4
`define BIT_GLOBAL_INT_ENABLE   7
`define BIT_LOW_SUPPLY_INT      6
`define BIT_WD_RESET_FLAG       7
`define BIT_WD_RUN_ENABLE       5
`define BIT_WD_RESTART          4
`define BIT_WD_COUNT_IN_SLEEP   3
`define BIT_BOOT_IMAGE_SELECT   6
`define BIT_SOFT_RESET_TRIGGER  5

`define RESET_VAL_BYTE          8'h00

`define CLK_FREQ_HZ             50000000
`define POR_HOLD_CLOCKS         8192
`define LONG_DELAY_MS           45
`define LONG_DELAY_CLOCKS       ((`CLK_FREQ_HZ / 1000) * `LONG_DELAY_MS)
`define PIN_HOLD_CLOCKS         24
`define PIN_HOLD_US             10
`define PIN_FILTER_CLOCKS       (`PIN_HOLD_CLOCKS + (`CLK_FREQ_HZ / 1000000) * `PIN_HOLD_US)
`define WD_TICK_DIVIDE          12
`define WD_TICK_LAST            4'hB

`endif

// *** hdl/reset_watchdog_unit.v ***
// Purpose: Reset merging, supply flags and watchdog behind the special register port
// Assumes: Analog detectors arrive as synchronous levels; options are static
// Notes:   Power-up and low-supply conditions wipe all but the pin filter and read data; soft and watchdog keep flags
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "reset_watchdog_regs.vh"

module reset_watchdog_unit #(
    parameter integer POR_CLOCKS  = `POR_HOLD_CLOCKS,
    parameter integer LONG_CLOCKS = `LONG_DELAY_CLOCKS,
    parameter integer PIN_CLOCKS  = `PIN_FILTER_CLOCKS
)(
    // Clock, reset, enable
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // Register port
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // Options and analog detectors
    input  wire       opt_pin_is_reset,
    input  wire       opt_long_delay,
    input  wire       supply_below_por,
    input  wire       low_supply_detect,
    input  wire       opt_low_supply_reset,
    input  wire       cpu_in_idle,
    // Shared reset pin
    input  wire       reset_pin_in,
    output wire       gpio_pin_in,
    // Results
    output reg        sys_reset,
    output reg        boot_monitor,
    output wire       low_supply_irq,
    output wire       low_supply_irq_high
);

    function [7:0] sel;
        input [7:0] a;
        input [7:0] b;
        begin
            sel = (a == b) ? 8'hFF : 8'h00;
        end
    endfunction

    localparam [1:0] ST_POR  = 2'd0;
    localparam [1:0] ST_LONG = 2'd1;
    localparam [1:0] ST_RUN  = 2'd2;
    localparam [1:0] ST_HOLD = 2'd3;

    localparam integer POR_LAST  = POR_CLOCKS - 1;
    localparam integer LONG_LAST = LONG_CLOCKS - 1;
    localparam integer PIN_LAST  = PIN_CLOCKS - 1;

    reg  [1:0]  state_q;
    reg  [22:0] delay_q;
    reg         low_supply_flag_q;
    reg         power_on_flag_q;
    reg  [5:0]  power_misc_q;
    reg         global_int_enable_q;
    reg  [5:0]  int_enable_misc_q;
    reg         low_supply_int_enable_q;
    reg  [7:0]  int_priority_q;
    reg         watchdog_reset_flag_q;
    reg         watchdog_run_enable_q;
    reg         watchdog_count_in_sleep_q;
    reg  [2:0]  prescale_sel_q;
    reg         boot_image_select_q;
    reg         flash_access_enable_q;
    reg  [3:0]  boot_misc_q;
    reg  [3:0]  tick_div_q;
    reg  [7:0]  prescale_q;
    reg  [14:0] wd_count_q;
    reg         pin_level_q;
    reg  [9:0]  pin_cnt_q;
    reg         soft_req_q;
    reg         wd_req_q;

    wire hard_reset = rst | supply_below_por | (opt_low_supply_reset & low_supply_detect);
    wire pin_reset  = opt_pin_is_reset & ~pin_level_q;
    wire soft_wr    = wr & sel(addr, `ADDR_BOOT_PROGRAM_CTRL) != 8'h00;
    wire wd_wr      = wr & sel(addr, `ADDR_WATCHDOG_CONTROL) != 8'h00;
    wire power_control_wr    = wr & sel(addr, `ADDR_POWER_CONTROL) != 8'h00;
    wire wd_counts  = watchdog_run_enable_q & (~cpu_in_idle | watchdog_count_in_sleep_q);
    wire [7:0] pre_top = (8'h02 << prescale_sel_q) - 8'h01;
    wire tick_end   = (tick_div_q == `WD_TICK_LAST);
    wire pre_end    = (prescale_q == pre_top);
    wire wd_tick    = tick_end & pre_end;
    wire wd_over    = wd_counts & wd_tick & (wd_count_q == 15'h7FFF);
    wire in_reset   = (state_q != ST_RUN);

    assign gpio_pin_in         = opt_pin_is_reset ? 1'b1 : reset_pin_in;
    assign low_supply_irq      = global_int_enable_q & low_supply_int_enable_q & low_supply_flag_q;
    assign low_supply_irq_high = int_priority_q[`BIT_LOW_SUPPLY_INT];

    // Pin filter: a level counts only after it has stood for the hold time
    always @(posedge clk)
    begin
        if (rst)
        begin
            pin_level_q <= 1'b1;
            pin_cnt_q   <= 10'h000;
        end
        else if (ce)
        begin
            if (reset_pin_in == pin_level_q)
                pin_cnt_q <= 10'h000;
            else if ({22'h000000, pin_cnt_q} == PIN_LAST)
            begin
                pin_level_q <= reset_pin_in;
                pin_cnt_q   <= 10'h000;
            end
            else
                pin_cnt_q <= pin_cnt_q + 10'h001;
        end
    end

    // Reset sequencer
    always @(posedge clk)
    begin
        if (hard_reset)
        begin
            state_q   <= ST_POR;
            delay_q   <= 23'h000000;
            sys_reset <= 1'b1;
        end
        else if (ce)
        begin
            case (state_q)
                ST_POR:
                begin
                    if ({9'h000, delay_q} == POR_LAST)
                    begin
                        delay_q <= 23'h000000;
                        state_q <= opt_long_delay ? ST_LONG : ST_RUN;
                    end
                    else
                        delay_q <= delay_q + 23'h000001;
                end
                ST_LONG:
                begin
                    if ({9'h000, delay_q} == LONG_LAST)
                    begin
                        delay_q <= 23'h000000;
                        state_q <= ST_RUN;
                    end
                    else
                        delay_q <= delay_q + 23'h000001;
                end
                ST_RUN:
                begin
                    if (pin_reset | soft_req_q | wd_req_q)
                        state_q <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    if (~pin_reset)
                        state_q <= ST_RUN;
                end
                default:
                    state_q <= ST_POR;
            endcase
            sys_reset <= (state_q != ST_RUN) | pin_reset | soft_req_q | wd_req_q;
        end
    end

    // Control bits except boot select fall back to defaults on any internal reset; flags and boot select only on a hard one
    wire ctl_reset = hard_reset | (ce & sys_reset & (state_q != ST_RUN));
    wire ie_wr     = wr & sel(addr, `ADDR_INTERRUPT_ENABLE) != 8'h00;
    wire ip_wr     = wr & sel(addr, `ADDR_INTERRUPT_PRIORITY) != 8'h00;
    wire wd_clear  = wd_wr & wdata[`BIT_WD_RESTART];

    // Low-supply flag; the detector wins over a clear in the same cycle
    always @(posedge clk)
    begin
        if (hard_reset)
            low_supply_flag_q <= 1'b1;
        else if (ce)
        begin
            if (low_supply_detect)
                low_supply_flag_q <= 1'b1;
            else if (power_control_wr & ~wdata[`BIT_LOW_SUPPLY_FLAG])
                low_supply_flag_q <= 1'b0;
        end
    end

    // Power-on flag
    always @(posedge clk)
    begin
        if (hard_reset)
            power_on_flag_q <= 1'b1;
        else if (ce & power_control_wr & ~wdata[`BIT_POWER_ON_FLAG])
            power_on_flag_q <= 1'b0;
    end

    // Survives its own reset so software can tell the cause afterwards
    always @(posedge clk)
    begin
        if (hard_reset)
            watchdog_reset_flag_q <= 1'b0;
        else if (ce)
        begin
            if (wd_over)
                watchdog_reset_flag_q <= 1'b1;
            else if (wd_wr & ~wdata[`BIT_WD_RESET_FLAG])
                watchdog_reset_flag_q <= 1'b0;
        end
    end

    // Boot image choice; refused while a reset is still in progress
    always @(posedge clk)
    begin
        if (hard_reset)
        begin
            boot_image_select_q <= 1'b0;
            boot_monitor        <= 1'b0;
        end
        else if (ce)
        begin
            if (soft_wr & ~in_reset)
                boot_image_select_q <= wdata[`BIT_BOOT_IMAGE_SELECT];
            if (state_q == ST_HOLD)
                boot_monitor <= boot_image_select_q;
        end
    end

    // Mode and general bits are only stored; sleep control sits elsewhere
    always @(posedge clk)
    begin
        if (ctl_reset)
            power_misc_q <= 6'h00;
        else if (ce & power_control_wr)
            power_misc_q <= {wdata[7:6], wdata[3:0]};
    end

    // Interrupt enable
    always @(posedge clk)
    begin
        if (ctl_reset)
        begin
            global_int_enable_q     <= 1'b0;
            low_supply_int_enable_q <= 1'b0;
            int_enable_misc_q       <= 6'h00;
        end
        else if (ce & ie_wr)
        begin
            global_int_enable_q     <= wdata[`BIT_GLOBAL_INT_ENABLE];
            low_supply_int_enable_q <= wdata[`BIT_LOW_SUPPLY_INT];
            int_enable_misc_q       <= wdata[5:0];
        end
    end

    // Interrupt priority
    always @(posedge clk)
    begin
        if (ctl_reset)
            int_priority_q <= `RESET_VAL_BYTE;
        else if (ce & ip_wr)
            int_priority_q <= wdata;
    end

    // Trigger lives one cycle only, so it can never fire twice
    always @(posedge clk)
    begin
        if (ctl_reset)
        begin
            flash_access_enable_q <= 1'b0;
            boot_misc_q           <= 4'h0;
            soft_req_q            <= 1'b0;
        end
        else if (ce)
        begin
            if (soft_wr)
            begin
                flash_access_enable_q <= wdata[7];
                boot_misc_q           <= wdata[3:0];
            end
            soft_req_q <= soft_wr & wdata[`BIT_SOFT_RESET_TRIGGER];
        end
    end

    // Watchdog control
    always @(posedge clk)
    begin
        if (ctl_reset)
        begin
            watchdog_run_enable_q     <= 1'b0;
            watchdog_count_in_sleep_q <= 1'b0;
            prescale_sel_q            <= 3'h0;
        end
        else if (ce & wd_wr)
        begin
            watchdog_run_enable_q     <= wdata[`BIT_WD_RUN_ENABLE];
            watchdog_count_in_sleep_q <= wdata[`BIT_WD_COUNT_IN_SLEEP];
            prescale_sel_q            <= wdata[2:0];
        end
    end

    // Registered so the overflow reset starts on a clean edge
    always @(posedge clk)
    begin
        if (ctl_reset)
            wd_req_q <= 1'b0;
        else if (ce)
            wd_req_q <= wd_over;
    end

    // Twelve clocks make one prescaler step
    always @(posedge clk)
    begin
        if (ctl_reset)
            tick_div_q <= 4'h0;
        else if (ce)
        begin
            if (wd_clear)
                tick_div_q <= 4'h0;
            else if (wd_counts)
            begin
                if (tick_end)
                    tick_div_q <= 4'h0;
                else
                    tick_div_q <= tick_div_q + 4'h1;
            end
        end
    end

    // Prescaler
    always @(posedge clk)
    begin
        if (ctl_reset)
            prescale_q <= 8'h00;
        else if (ce)
        begin
            if (wd_clear)
                prescale_q <= 8'h00;
            else if (wd_counts & tick_end)
            begin
                if (pre_end)
                    prescale_q <= 8'h00;
                else
                    prescale_q <= prescale_q + 8'h01;
            end
        end
    end

    // Restart clears the whole chain so the full interval always follows
    always @(posedge clk)
    begin
        if (ctl_reset)
            wd_count_q <= 15'h0000;
        else if (ce)
        begin
            if (wd_clear)
                wd_count_q <= 15'h0000;
            else if (wd_counts & tick_end & pre_end)
                wd_count_q <= wd_count_q + 15'h0001;
        end
    end

    // Read port; restart and soft-reset bits always read zero
    always @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (ce & rd)
        begin
            case (addr)
                `ADDR_POWER_CONTROL:
                    rdata <= {power_misc_q[5:4], low_supply_flag_q, power_on_flag_q, power_misc_q[3:0]};
                `ADDR_INTERRUPT_ENABLE:
                    rdata <= {global_int_enable_q, low_supply_int_enable_q, int_enable_misc_q};
                `ADDR_INTERRUPT_PRIORITY:
                    rdata <= int_priority_q;
                `ADDR_WATCHDOG_CONTROL:
                    rdata <= {watchdog_reset_flag_q, 1'b0, watchdog_run_enable_q, 1'b0,
                              watchdog_count_in_sleep_q, prescale_sel_q};
                `ADDR_BOOT_PROGRAM_CTRL:
                    rdata <= {flash_access_enable_q, boot_image_select_q, 2'b00, boot_misc_q};
                default:
                    rdata <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** testbench/reset_watchdog_monitor.sv ***
// Purpose: Port checks for the reset and watchdog unit
// Assumes: Clock enable held high while checked
// Notes:   Watchdog overflow is too slow to assert on here
`timescale 1ns/100ps
`default_nettype none
module reset_watchdog_monitor #(
    parameter int POR_CLOCKS  = 16,
    parameter int LONG_CLOCKS = 20
)(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Options and pin
    input wire logic       opt_pin_is_reset,
    input wire logic       opt_long_delay,
    input wire logic       supply_below_por,
    input wire logic       reset_pin_in,
    input wire logic       gpio_pin_in,
    // Results
    input wire logic       sys_reset,
    input wire logic       boot_monitor,
    input wire logic       low_supply_irq,
    input wire logic       low_supply_irq_high
);
    localparam int REL_MAX   = POR_CLOCKS + 8;
    localparam int LONG_HOLD = POR_CLOCKS + LONG_CLOCKS - 4;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    por_hold_a: assert property (
        $fell(rst) && !opt_long_delay |-> sys_reset [*8] ##[1:REL_MAX] !sys_reset)
        else $error("power-up hold wrong");
    long_hold_a: assert property (
        $fell(rst) && opt_long_delay |-> ##LONG_HOLD sys_reset)
        else $error("long delay missing");
    soft_go_a: assert property (
        wr && addr == 8'hC7 && wdata[5] && !sys_reset |-> ##[1:2] sys_reset ##[1:6] !sys_reset)
        else $error("soft reset pulse wrong");
    boot_mon_a: assert property (
        wr && addr == 8'hC7 && wdata[6:5] == 2'b11 && !sys_reset |-> ##[2:4] boot_monitor)
        else $error("monitor image not chosen");
    boot_app_a: assert property (
        wr && addr == 8'hC7 && wdata[6:5] == 2'b01 && !sys_reset |-> ##[2:4] !boot_monitor)
        else $error("application image not chosen");
    irq_gate_a: assert property (
        rd && addr == 8'hA8 && !sys_reset ##1 rdata[7:6] != 2'b11 |-> !low_supply_irq)
        else $error("interrupt passes a closed gate");
    irq_prio_a: assert property (
        rd && addr == 8'hB8 && !sys_reset ##1 1'b1 |-> low_supply_irq_high == rdata[6])
        else $error("priority output differs from register");
    gpio_pass_a: assert property (
        gpio_pin_in == (opt_pin_is_reset | reset_pin_in))
        else $error("pin input path wrong");
    pin_hold_a: assert property (
        (opt_pin_is_reset && !reset_pin_in) [*8] |-> ##2 sys_reset)
        else $error("pin reset not taken");
    por_detect_a: assert property (
        supply_below_por |-> ##[1:2] sys_reset)
        else $error("supply loss reset missing");
endmodule
bind reset_watchdog_unit reset_watchdog_monitor #(.POR_CLOCKS(POR_CLOCKS), .LONG_CLOCKS(LONG_CLOCKS)) mon (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .opt_pin_is_reset(opt_pin_is_reset), .opt_long_delay(opt_long_delay), .supply_below_por(supply_below_por),
    .reset_pin_in(reset_pin_in), .gpio_pin_in(gpio_pin_in), .sys_reset(sys_reset), .boot_monitor(boot_monitor),
    .low_supply_irq(low_supply_irq), .low_supply_irq_high(low_supply_irq_high));
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the reset and watchdog unit
// Assumes: Short power-up, long-delay and pin filter counts
// Notes:   Watchdog overflow needs ~786k clocks; only its control path is run
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
    localparam int POR = 16;
    localparam int LNG = 20;
    logic        clk, rst, ce, wr, rd, rd_d;
    logic [7:0]  addr, wdata, rdata;
    logic        opt_pin, opt_long, below_por, low_det, idle, pin, lv_rst;
    logic        gpio, sys_reset, boot_mon, irq, irq_hi;
    int          n_fail, total_checks, cnt;
    logic [31:0] seed;
    logic [15:0] notes[$];
    logic [15:0] nt;

    reset_watchdog_unit #(.POR_CLOCKS(POR), .LONG_CLOCKS(LNG), .PIN_CLOCKS(4)) dut (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .opt_pin_is_reset(opt_pin), .opt_long_delay(opt_long), .supply_below_por(below_por),
        .low_supply_detect(low_det), .opt_low_supply_reset(lv_rst), .cpu_in_idle(idle),
        .reset_pin_in(pin), .gpio_pin_in(gpio), .sys_reset(sys_reset), .boot_monitor(boot_mon),
        .low_supply_irq(irq), .low_supply_irq_high(irq_hi));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Read data stand one cycle after the strobe, so notes lag one edge
    always @(posedge clk)
    begin
        rd_d <= rd;
        if (rd_d === 1'b1)
        begin
            nt = notes.pop_front();
            `CHK("read data", nt[7:0], rdata & nt[15:8])
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Mask keeps undefined bits out of the comparison
    task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        notes.push_back({m, e});
        @(posedge clk);
        rd   <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_rst(input logic lvl);
        cnt = 0;
        while (sys_reset !== lvl && cnt < 400)
        begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= 400)
        begin
            n_fail++;
            $display("mismatch sys_reset expected %h seen %h", lvl, sys_reset);
            conclude();
        end
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    initial
    begin
        {rst, ce, wr, rd, addr, wdata} = {2'b11, 2'b00, 16'h0000};
        {lv_rst, opt_pin, opt_long, below_por, low_det, idle, pin} = 7'b0000001;
        {n_fail, total_checks} = 0;
        seed = 32'h61A4;
        cyc(20);
        rst <= 1'b0;
        wait_rst(1'b0);
        `CHK("power-up hold", 1'b1, cnt >= POR)
        rreg(8'h87, 8'h30, 8'h30);
        rreg(8'hC1, 8'h80, 8'h00);
        rreg(8'hA8, 8'hFF, 8'h00);
        rreg(8'hB8, 8'hFF, 8'h00);
        rreg(8'h00, 8'hFF, 8'h00);
        done("power-up");
        wreg(8'h87, 8'h00);
        rreg(8'h87, 8'h30, 8'h00);
        low_det <= 1'b1;
        wreg(8'h87, 8'h00);
        low_det <= 1'b0;
        rreg(8'h87, 8'h30, 8'h20);
        wreg(8'hA8, 8'h40);
        cyc(1);
        `CHK("irq gated", 1'b0, irq)
        wreg(8'hA8, 8'hC0);
        cyc(1);
        `CHK("irq raised", 1'b1, irq)
        wreg(8'hB8, 8'h40);
        rreg(8'hB8, 8'h40, 8'h40);
        wreg(8'h87, 8'h00);
        cyc(1);
        `CHK("irq cleared", 1'b0, irq)
        done("low supply");
        wreg(8'hC7, 8'h60);
        wait_rst(1'b1);
        wait_rst(1'b0);
        `CHK("monitor image", 1'b1, boot_mon)
        rreg(8'hC7, 8'h20, 8'h00);
        rreg(8'hA8, 8'hFF, 8'h00);
        rreg(8'h87, 8'h10, 8'h00);
        wreg(8'hC7, 8'h20);
        wait_rst(1'b1);
        wait_rst(1'b0);
        `CHK("application image", 1'b0, boot_mon)
        done("soft reset");
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            idle <= seed[9];
            wreg(8'hC1, {4'b0011, seed[3:0]});
            rreg(8'hC1, 8'h7F, {4'b0010, seed[3:0]});
            cyc(200);
            `CHK("no early overflow", 1'b0, sys_reset)
        end
        wreg(8'hC1, 8'h00);
        rreg(8'hC1, 8'h20, 8'h00);
        done("watchdog control");
        opt_long <= 1'b1;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        wait_rst(1'b0);
        `CHK("long delay", 1'b1, cnt >= POR + LNG)
        opt_long <= 1'b0;
        rreg(8'h87, 8'h30, 8'h30);
        done("long delay");
        opt_pin <= 1'b1;
        cyc(2);
        `CHK("pin taken", 1'b1, gpio)
        pin <= 1'b0;
        cyc(12);
        `CHK("pin reset", 1'b1, sys_reset)
        pin <= 1'b1;
        wait_rst(1'b0);
        opt_pin <= 1'b0;
        pin <= 1'b0;
        cyc(12);
        `CHK("gpio level", 1'b0, gpio)
        `CHK("gpio no reset", 1'b0, sys_reset)
        pin <= 1'b1;
        done("reset pin");
        wreg(8'h87, 8'h00);
        low_det <= 1'b1;
        cyc(3);
        `CHK("low supply no option", 1'b0, sys_reset)
        lv_rst <= 1'b1;
        cyc(3);
        `CHK("low supply reset", 1'b1, sys_reset)
        low_det <= 1'b0;
        lv_rst  <= 1'b0;
        wait_rst(1'b0);
        rreg(8'h87, 8'h30, 8'h30);
        done("low supply reset");
        wreg(8'h87, 8'h00);
        below_por <= 1'b1;
        cyc(3);
        `CHK("supply loss", 1'b1, sys_reset)
        below_por <= 1'b0;
        ce        <= 1'b0;
        cyc(30);
        `CHK("frozen hold", 1'b1, sys_reset)
        ce <= 1'b1;
        wait_rst(1'b0);
        `CHK("hold after freeze", 1'b1, cnt >= POR)
        rreg(8'h87, 8'h30, 8'h30);
        rreg(8'hC1, 8'h80, 8'h00);
        done("supply loss");
        cyc(3);
        conclude();
    end
endmodule
`default_nettype wire
